// ---- rtl/adc_seq_pkg.sv ----
// Constants and types shared by the converter sequencer design.
// Behaviour
// - Exactly one of eight analog channels routed to sample stage per conversion.
// - Sample in two phases: amplifier precharge, then direct input connection.
// - Sample stage clock gated off when idle; power-up clear stops analog too.
// - Result is 8 or 10 bits by successive approximation binary search.
// - Conversion machine clock gated off when no conversion runs.
// - Trigger taken from channel 7, edge or level, selectable polarity.
// - Trigger off, scan off: ignore pin, run one sequence, stop.
// - Trigger off, scan on: ignore pin, run sequences back to back.
// - Edge mode, polarity 0: each falling edge starts one sequence.
// - Edge mode, polarity 1: each rising edge starts one sequence.
// - Level mode, polarity 0: convert continuously while trigger low.
// - Level mode, polarity 1: convert continuously while trigger high.
// - Active edge during running conversion sets the trigger overrun flag.
// - First conversion starts two clocks after trigger recognition.
// - First conversion of triggered sequence starts two clocks after trigger receipt.
// - With trigger enabled, software start writes start nothing.
// - Level mode trigger drop and return mid sequence is no overrun.
// - Level mode trigger still active at sequence end restarts at once.
// - Digital input buffer per channel switched by input enable register.
// - Stop mode halts conversion; leaving it resumes conversion.
// - Wait mode with halt-in-wait set halts conversion; exit resumes.
// - Clearing power-up aborts conversion; registers stay accessible.
// - Port data reads 1 for each channel whose buffer is disabled.
package adc_seq_pkg;
    localparam int          NUM_CHAN      = 8;
    localparam int          TRIG_CHAN     = 7;
    localparam int          RES_HI        = 10;
    localparam int          RES_LO        = 8;
    // Sample phase lengths in clock cycles
    localparam logic [3:0]  PRECHARGE_CYC = 4'h2;
    localparam logic [3:0]  DIRECT_CYC    = 4'h4;
    // Reset values
    localparam logic [7:0]  DIEN_RESET    = 8'h00;
    localparam logic [7:0]  PORT_RESET    = 8'hff;
    localparam logic [9:0]  RESULT_RESET  = 10'h000;
    localparam logic [2:0]  CHAN_RESET    = 3'h0;
    localparam logic [3:0]  LEN_RESET     = 4'h1;

    typedef enum logic [2:0] {
        ST_IDLE   = 3'b000,
        ST_PRECH  = 3'b001,
        ST_DIRECT = 3'b010,
        ST_CONV   = 3'b011,
        ST_STORE  = 3'b100
    } conv_state_t;
endpackage

// ---- rtl/sar_if.sv ----
// Interface between sequencer and successive approximation engine.
`timescale 1ns/100ps
interface sar_if;
    logic       start;
    logic       res10;
    logic       comp_in;
    logic [9:0] dac_code;
    logic       busy;
    logic       done;
    logic [9:0] result;
    modport seq (output start, output res10, output comp_in,
                 input dac_code, input busy, input done, input result);
    modport sar (input start, input res10, input comp_in,
                 output dac_code, output busy, output done, output result);
endinterface

// ---- rtl/trig_detect.sv ----
// Trigger synchroniser with polarity, edge and level qualification.
`timescale 1ns/100ps
module trig_detect (
    // Clock and reset
    input  wire logic clk,
    input  wire logic rst_n,
    // Trigger pin and configuration
    input  wire logic trig_raw,
    input  wire logic trig_polarity,
    // Qualified trigger
    output logic      trig_active,
    output logic      trig_edge
);
    logic sync1;
    logic sync2;
    logic prev;
    wire  active_now = sync2 ~^ trig_polarity;

    // Two flop synchroniser then edge history
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            sync1 <= 1'b1;           // Idle pad level is high
            sync2 <= 1'b1;
            prev  <= 1'b1;           // No false edge just after reset
        end else begin
            sync1 <= trig_raw;
            sync2 <= sync1;
            prev  <= active_now;
        end
    end

    // Polarity selects falling or rising as active
    assign trig_active = active_now;
    assign trig_edge   = active_now & ~prev;
endmodule

// ---- rtl/sar_engine.sv ----
// Successive approximation search engine, 8 or 10 bits.
`timescale 1ns/100ps
module sar_engine (
    // Clock and reset
    input  wire logic clk,
    input  wire logic rst_n,
    // Sequencer side
    sar_if.sar        sar
);
    import adc_seq_pkg::*;
    logic [9:0] trial;
    logic [9:0] bitmask;
    logic       running;

    wire [9:0] first_mask = sar.res10 ? 10'h200 : 10'h080;
    wire [9:0] keep       = sar.comp_in ? trial : (trial & ~bitmask);
    wire       last       = bitmask[0];
    // Coming trial code, so the registered DAC code matches the bit under test
    wire [9:0] next_trial = sar.start ? first_mask
                          : running ? (last ? keep : (keep | (bitmask >> 1))) : trial;

    // Binary search, one bit per clock; idle flops hold still
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            trial   <= RESULT_RESET;
            bitmask <= RESULT_RESET;
            running <= 1'b0;
        end else if (sar.start) begin
            trial   <= first_mask;
            bitmask <= first_mask;
            running <= 1'b1;
        end else if (running) begin
            bitmask <= bitmask >> 1;
            trial   <= last ? keep : (keep | (bitmask >> 1));
            running <= ~last;
        end
    end

    // Done pulses when last bit settles
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            sar.done   <= 1'b0;
            sar.result <= RESULT_RESET;
        end else begin
            sar.done <= running & last;
            if (running & last) begin
                sar.result <= keep;
            end
        end
    end

    assign sar.dac_code = next_trial;
    assign sar.busy     = running;
endmodule

// ---- rtl/adc_trigger_sequencer.sv ----
// Top of the converter sequencer: trigger, modes, sampling, port data.
`timescale 1ns/100ps
module adc_trigger_sequencer (
    // Clock and reset
    input  wire logic                 SYS_CLK,
    input  wire logic                 RST_N,
    // Control bits
    input  wire logic                 CONVERTER_POWER_UP,
    input  wire logic                 SEQUENCE_START_CTRL_WR,
    input  wire logic                 SCAN_MODE,
    input  wire logic                 RES10_MODE,
    input  wire logic [3:0]           SEQ_LENGTH,
    input  wire logic [2:0]           START_CHAN,
    input  wire logic                 TRIG_ENABLE,
    input  wire logic                 TRIG_LEVEL_MODE,
    input  wire logic                 TRIG_POLARITY,
    input  wire logic                 TRIG_OVERRUN_CLR,
    input  wire logic                 SEQ_COMPLETE_IRQ_EN,
    input  wire logic                 SEQ_COMPLETE_CLR,
    input  wire logic [7:0]           DIGITAL_INPUT_ENABLE_REG,
    // Low power
    input  wire logic                 STOP_MODE,
    input  wire logic                 WAIT_MODE,
    input  wire logic                 HALT_IN_WAIT,
    // Pads and analog front end
    input  wire logic [7:0]           PAD_IN,
    input  wire logic                 COMPARATOR,
    output logic [7:0]                CHAN_SEL_ONEHOT,
    output logic                      AMP_PRECHARGE,
    output logic                      DIRECT_CONNECT,
    output logic                      SH_CLK_EN,
    output logic                      SAR_CLK_EN,
    output logic                      ANALOG_POWER,
    output logic [9:0]                DAC_CODE,
    output logic [7:0]                DIGITAL_BUF_EN,
    // Status and results
    output logic [7:0]                PIN_INPUT_PORT,
    output logic [9:0]                RESULT,
    output logic [2:0]                RESULT_CHAN,
    output logic                      RESULT_VALID,
    output logic                      BUSY,
    output logic                      TRIG_OVERRUN_FLAG,
    output logic                      SEQ_COMPLETE_FLAG,
    output logic                      SEQ_COMPLETE_IRQ
);
    import adc_seq_pkg::*;

    sar_if       sar ();
    conv_state_t state;
    conv_state_t next_state;
    logic [3:0]  phase_cnt;
    logic [3:0]  conv_cnt;
    logic [2:0]  chan;
    logic        seq_run;
    logic [7:0]  pad_s1;
    logic [7:0]  pad_s2;
    logic        start_pend;
    logic        trig_active;
    logic        trig_edge;
    logic        sar_start;

    // Channel 7 trigger detection
    trig_detect u_trig (
        .clk           (SYS_CLK),
        .rst_n         (RST_N),
        .trig_raw      (PAD_IN[TRIG_CHAN]),
        .trig_polarity (TRIG_POLARITY),
        .trig_active   (trig_active),
        .trig_edge     (trig_edge)
    );

    // Search engine
    sar_engine u_sar (
        .clk   (SYS_CLK),
        .rst_n (RST_N),
        .sar   (sar)
    );

    // Halting and abort conditions
    wire halted   = STOP_MODE | (WAIT_MODE & HALT_IN_WAIT);
    wire abort    = ~CONVERTER_POWER_UP;
    wire seq_len0 = (SEQ_LENGTH == 4'h0);
    wire [3:0] seq_len = seq_len0 ? LEN_RESET : SEQ_LENGTH;

    // Start sources
    wire sw_start   = SEQUENCE_START_CTRL_WR & ~TRIG_ENABLE;
    wire edge_start = TRIG_ENABLE & ~TRIG_LEVEL_MODE & trig_edge;
    wire lvl_start  = TRIG_ENABLE & TRIG_LEVEL_MODE & trig_active;
    wire any_start  = sw_start | edge_start | lvl_start | start_pend;

    // Phase and sequence progress
    wire phase_done = (phase_cnt == 4'h1);
    wire last_conv  = (conv_cnt == seq_len - 4'h1);
    wire conv_end   = (state == ST_STORE);
    wire seq_end    = conv_end & last_conv;
    wire rerun      = (~TRIG_ENABLE & SCAN_MODE)
                    | (TRIG_ENABLE & TRIG_LEVEL_MODE & trig_active);
    wire busy_now   = seq_run;

    // Overrun: edge mode only, active edge while running
    wire overrun_set = TRIG_ENABLE & ~TRIG_LEVEL_MODE & trig_edge & busy_now;

    // Next state of sample and convert machine
    always_comb begin
        next_state = state;
        unique case (state)
            ST_IDLE: begin
                if (seq_run & ~halted) begin
                    next_state = ST_PRECH;
                end
            end
            ST_PRECH: begin
                if (phase_done) begin
                    next_state = ST_DIRECT;
                end
            end
            ST_DIRECT: begin
                if (phase_done) begin
                    next_state = ST_CONV;
                end
            end
            ST_CONV: begin
                if (sar.done) begin
                    next_state = ST_STORE;
                end
            end
            ST_STORE: begin
                next_state = ST_IDLE;
            end
            default: begin
                next_state = ST_IDLE;
            end
        endcase
    end

    // State register; abort takes priority, halt freezes it except on engine done
    always_ff @(posedge SYS_CLK) begin
        if (!RST_N || abort) begin
            state <= ST_IDLE;
        end else if (!halted || (state == ST_CONV && sar.done)) begin
            state <= next_state;                              // done pulse not lost
        end
    end

    // Phase counter loaded on each sample phase entry
    always_ff @(posedge SYS_CLK) begin
        if (!RST_N) begin
            phase_cnt <= 4'h0;
        end else if (!halted) begin
            if (state == ST_IDLE || (state == ST_PRECH && phase_done)) begin
                phase_cnt <= (state == ST_IDLE) ? PRECHARGE_CYC : DIRECT_CYC;
            end else if (phase_cnt != 4'h0) begin
                phase_cnt <= phase_cnt - 4'h1;
            end
        end
    end

    // Pending start held while a halt keeps the machine frozen
    always_ff @(posedge SYS_CLK) begin
        if (!RST_N || abort) begin
            start_pend <= 1'b0;
        end else begin
            start_pend <= halted & any_start & ~seq_run;
        end
    end

    // Sequence run flag, counter and channel pointer
    always_ff @(posedge SYS_CLK) begin
        if (!RST_N || abort) begin
            seq_run  <= 1'b0;
            conv_cnt <= 4'h0;
            chan     <= CHAN_RESET;
        end else if (!seq_run && any_start && !halted) begin
            seq_run  <= 1'b1;
            conv_cnt <= 4'h0;
            chan     <= START_CHAN;
        end else if (conv_end && !halted) begin
            conv_cnt <= last_conv ? 4'h0 : conv_cnt + 4'h1;
            chan     <= last_conv ? START_CHAN : chan + 3'h1;
            seq_run  <= ~last_conv | rerun;
        end
    end

    // Engine start at end of direct phase
    assign sar_start   = (state == ST_DIRECT) & phase_done & ~halted;
    assign sar.start   = sar_start;
    assign sar.res10   = RES10_MODE;
    assign sar.comp_in = COMPARATOR;

    // Pad synchroniser for port data
    always_ff @(posedge SYS_CLK) begin
        if (!RST_N) begin
            pad_s1 <= PORT_RESET;
            pad_s2 <= PORT_RESET;
        end else begin
            pad_s1 <= PAD_IN;
            pad_s2 <= pad_s1;
        end
    end

    // Port data and buffer enables
    always_ff @(posedge SYS_CLK) begin
        if (!RST_N) begin
            PIN_INPUT_PORT <= PORT_RESET;
            DIGITAL_BUF_EN <= DIEN_RESET;
        end else begin
            PIN_INPUT_PORT <= pad_s2 | ~DIGITAL_INPUT_ENABLE_REG;
            DIGITAL_BUF_EN <= DIGITAL_INPUT_ENABLE_REG;
        end
    end

    // Analog front end controls
    wire       sampling  = (state == ST_PRECH) | (state == ST_DIRECT);
    wire [7:0] chan_hot  = 8'h01 << chan;
    always_ff @(posedge SYS_CLK) begin
        if (!RST_N) begin
            CHAN_SEL_ONEHOT <= 8'h00;
            AMP_PRECHARGE   <= 1'b0;
            DIRECT_CONNECT  <= 1'b0;
            SH_CLK_EN       <= 1'b0;
            SAR_CLK_EN      <= 1'b0;
            ANALOG_POWER    <= 1'b0;
            DAC_CODE        <= RESULT_RESET;
        end else begin
            CHAN_SEL_ONEHOT <= sampling ? chan_hot : 8'h00;
            AMP_PRECHARGE   <= (next_state == ST_PRECH) & ~halted & ~abort;
            DIRECT_CONNECT  <= (next_state == ST_DIRECT) & ~halted & ~abort;
            SH_CLK_EN       <= sampling & ~halted;
            SAR_CLK_EN      <= (sar.busy | sar_start) & ~halted & ~abort;
            ANALOG_POWER    <= CONVERTER_POWER_UP;
            DAC_CODE        <= sar.dac_code;
        end
    end

    // Results, busy and flags; set wins over clear
    always_ff @(posedge SYS_CLK) begin
        if (!RST_N) begin
            RESULT            <= RESULT_RESET;
            RESULT_CHAN       <= CHAN_RESET;
            RESULT_VALID      <= 1'b0;
            BUSY              <= 1'b0;
            TRIG_OVERRUN_FLAG <= 1'b0;
            SEQ_COMPLETE_FLAG <= 1'b0;
            SEQ_COMPLETE_IRQ  <= 1'b0;
        end else begin
            RESULT_VALID <= conv_end & ~halted & ~abort;
            if (conv_end && !halted && !abort) begin
                RESULT      <= sar.result;
                RESULT_CHAN <= chan;
            end
            BUSY <= seq_run & ~abort;
            if (overrun_set) begin
                TRIG_OVERRUN_FLAG <= 1'b1;
            end else if (TRIG_OVERRUN_CLR || (any_start && !seq_run)) begin
                TRIG_OVERRUN_FLAG <= 1'b0;
            end
            if (seq_end && !halted && !abort) begin
                SEQ_COMPLETE_FLAG <= 1'b1;
            end else if (SEQ_COMPLETE_CLR) begin
                SEQ_COMPLETE_FLAG <= 1'b0;
            end
            SEQ_COMPLETE_IRQ <= SEQ_COMPLETE_IRQ_EN &
                ((seq_end & ~halted & ~abort) | (SEQ_COMPLETE_FLAG & ~SEQ_COMPLETE_CLR));
        end
    end
endmodule

// ---- sim/adc_trigger_sequencer_monitor.sv ----
// Port-level checker for the converter sequencer.
`timescale 1ns/100ps
module adc_trigger_sequencer_monitor (
    // Clock and reset
    input wire logic       SYS_CLK,
    input wire logic       RST_N,
    // Controls
    input wire logic       CONVERTER_POWER_UP,
    input wire logic       SEQUENCE_START_CTRL_WR,
    input wire logic       TRIG_ENABLE,
    input wire logic       TRIG_LEVEL_MODE,
    input wire logic       SEQ_COMPLETE_IRQ_EN,
    input wire logic [7:0] DIGITAL_INPUT_ENABLE_REG,
    input wire logic       STOP_MODE,
    input wire logic       WAIT_MODE,
    // Watched outputs
    input wire logic [7:0] CHAN_SEL_ONEHOT,
    input wire logic       AMP_PRECHARGE,
    input wire logic       DIRECT_CONNECT,
    input wire logic       SAR_CLK_EN,
    input wire logic       SH_CLK_EN,
    input wire logic       ANALOG_POWER,
    input wire logic [7:0] PIN_INPUT_PORT,
    input wire logic [9:0] RESULT,
    input wire logic       BUSY,
    input wire logic       TRIG_OVERRUN_FLAG,
    input wire logic       SEQ_COMPLETE_IRQ
);
    default clocking @(posedge SYS_CLK); endclocking
    default disable iff (!RST_N);
    logic pre_seen;
    // Precharge seen since the channel switch last opened
    always_ff @(posedge SYS_CLK) begin
        if (!RST_N || (CHAN_SEL_ONEHOT == 8'h00 && !AMP_PRECHARGE)) begin
            pre_seen <= 1'b0;
        end else if (AMP_PRECHARGE) begin
            pre_seen <= 1'b1;
        end
    end
    // Routing, sampling and gating
    AST_ONE_CHAN: assert property ($onehot0(CHAN_SEL_ONEHOT))
        else $error("more than one channel routed");
    AST_PHASE_ORDER: assert property ($rose(DIRECT_CONNECT) |-> pre_seen)
        else $error("direct phase without precharge");
    AST_SAR_GATED: assert property (!BUSY [*2] |-> !SAR_CLK_EN)
        else $error("conversion clock runs while idle");
    AST_SH_GATED: assert property (!BUSY [*2] |-> !SH_CLK_EN)
        else $error("sample clock runs while idle");
    AST_PWR_OFF: assert property (!CONVERTER_POWER_UP [*2] |-> !BUSY && !ANALOG_POWER)
        else $error("powered down yet active");
    // Start, trigger, flags
    AST_SW_START: assert property (SEQUENCE_START_CTRL_WR && !TRIG_ENABLE
        && CONVERTER_POWER_UP && !BUSY && !STOP_MODE && !WAIT_MODE |-> ##2 BUSY)
        else $error("software start not taken");
    AST_PORT_OFF: assert property (
        DIGITAL_INPUT_ENABLE_REG == $past(DIGITAL_INPUT_ENABLE_REG)
        && DIGITAL_INPUT_ENABLE_REG == $past(DIGITAL_INPUT_ENABLE_REG, 2)
        |-> &(PIN_INPUT_PORT | DIGITAL_INPUT_ENABLE_REG))
        else $error("disabled channel does not read one");
    AST_LEVEL_NO_OVR: assert property (TRIG_LEVEL_MODE && $past(TRIG_LEVEL_MODE)
        && $past(TRIG_LEVEL_MODE, 2) && !TRIG_OVERRUN_FLAG |=> !TRIG_OVERRUN_FLAG)
        else $error("overrun set in level mode");
    AST_IRQ_MASK: assert property (!SEQ_COMPLETE_IRQ_EN && !$past(SEQ_COMPLETE_IRQ_EN)
        |-> !SEQ_COMPLETE_IRQ)
        else $error("masked completion request raised");
    AST_HALT: assert property (STOP_MODE && $past(STOP_MODE) && $past(STOP_MODE, 2)
        && $past(CONVERTER_POWER_UP) && $past(CONVERTER_POWER_UP, 2)
        |-> $stable(RESULT) && $stable(BUSY))
        else $error("state moved while stopped");
endmodule

bind adc_trigger_sequencer adc_trigger_sequencer_monitor mon_u (
    .SYS_CLK(SYS_CLK), .RST_N(RST_N), .CONVERTER_POWER_UP(CONVERTER_POWER_UP),
    .SEQUENCE_START_CTRL_WR(SEQUENCE_START_CTRL_WR), .TRIG_ENABLE(TRIG_ENABLE),
    .TRIG_LEVEL_MODE(TRIG_LEVEL_MODE), .SEQ_COMPLETE_IRQ_EN(SEQ_COMPLETE_IRQ_EN),
    .DIGITAL_INPUT_ENABLE_REG(DIGITAL_INPUT_ENABLE_REG), .STOP_MODE(STOP_MODE),
    .WAIT_MODE(WAIT_MODE), .CHAN_SEL_ONEHOT(CHAN_SEL_ONEHOT), .AMP_PRECHARGE(AMP_PRECHARGE),
    .DIRECT_CONNECT(DIRECT_CONNECT), .SAR_CLK_EN(SAR_CLK_EN), .ANALOG_POWER(ANALOG_POWER),
    .SH_CLK_EN(SH_CLK_EN),
    .PIN_INPUT_PORT(PIN_INPUT_PORT), .RESULT(RESULT), .BUSY(BUSY),
    .TRIG_OVERRUN_FLAG(TRIG_OVERRUN_FLAG), .SEQ_COMPLETE_IRQ(SEQ_COMPLETE_IRQ)
);

// ---- sim/adc_front_model.sv ----
// Far-side model: pad levels, trigger pin and analog comparator.
`timescale 1ns/100ps
module adc_front_model (
    // Clock
    input  wire logic       clk,
    // Levels set by the bench
    input  wire logic [7:0] pad_lvl,
    // Converter side
    input  wire logic [7:0] chan_sel,
    input  wire logic [9:0] dac_code,
    output logic      [7:0] pad_in,
    output logic            comparator
);
    logic [2:0] held_chan = 3'h0;
    // Channel held from the last sampling phase
    always @(posedge clk) begin
        for (int i = 0; i < 8; i++) begin
            if (chan_sel[i]) begin
                held_chan <= i[2:0];
            end
        end
    end
    // Pad 7 doubles as the trigger pin
    assign pad_in = pad_lvl;
    // Each channel carries its own level, compared with the trial code
    assign comparator = ({held_chan, 7'h15} >= dac_code);
endmodule

// ---- sim/adc_trigger_sequencer_tb_top.sv ----
// Self-checking bench for the converter sequencer.
`timescale 1ns/100ps
module adc_trigger_sequencer_tb_top;
    logic       clk, rst_n, pwr, sw_go, scan, r10, ten, tlev, tpol;
    logic       oclr, ien, cclr, stp, wt, hiw;
    logic [3:0] len;
    logic [2:0] sch;
    logic [7:0] dien, pads;
    wire  [7:0] pad_in, csel, bufen, pin;
    wire  [9:0] dac, res;
    wire  [2:0] rch;
    wire        cmp, apw, rv, busy, ovf, cfl, irq;
    int         error_cnt, tests_run, nval, n0;
    logic [2:0] chq[$];
    logic [9:0] rq[$];

    adc_trigger_sequencer dut_u (
        .SYS_CLK(clk), .RST_N(rst_n), .CONVERTER_POWER_UP(pwr),
        .SEQUENCE_START_CTRL_WR(sw_go), .SCAN_MODE(scan), .RES10_MODE(r10),
        .SEQ_LENGTH(len), .START_CHAN(sch), .TRIG_ENABLE(ten), .TRIG_LEVEL_MODE(tlev),
        .TRIG_POLARITY(tpol), .TRIG_OVERRUN_CLR(oclr), .SEQ_COMPLETE_IRQ_EN(ien),
        .SEQ_COMPLETE_CLR(cclr), .DIGITAL_INPUT_ENABLE_REG(dien), .STOP_MODE(stp),
        .WAIT_MODE(wt), .HALT_IN_WAIT(hiw), .PAD_IN(pad_in), .COMPARATOR(cmp),
        .CHAN_SEL_ONEHOT(csel), .AMP_PRECHARGE(), .DIRECT_CONNECT(), .SH_CLK_EN(),
        .SAR_CLK_EN(), .ANALOG_POWER(apw), .DAC_CODE(dac), .DIGITAL_BUF_EN(bufen),
        .PIN_INPUT_PORT(pin), .RESULT(res), .RESULT_CHAN(rch), .RESULT_VALID(rv),
        .BUSY(busy), .TRIG_OVERRUN_FLAG(ovf), .SEQ_COMPLETE_FLAG(cfl),
        .SEQ_COMPLETE_IRQ(irq)
    );
    adc_front_model far_u (.clk(clk), .pad_lvl(pads), .chan_sel(csel), .dac_code(dac),
        .pad_in(pad_in), .comparator(cmp));

    // Clock
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    // Result log taken at each rising edge
    always @(posedge clk) begin
        if (rv === 1'b1) begin
            nval++;
            chq.push_back(rch);
            rq.push_back(res);
        end
    end

    task automatic chk(input logic ok, input string m);
        tests_run++;
        if (ok !== 1'b1) begin
            error_cnt++;
            $display("MISMATCH %0t %s", $time, m);
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(negedge clk);
    endtask
    task automatic pulse(ref logic s);
        s = 1'b1;
        cyc(1);
        s = 1'b0;
    endtask
    // Wait goal: -1 busy, 0 idle, n results since n0
    function automatic logic met(input int what);
        return what < 0 ? busy === 1'b1 : what == 0 ? busy === 1'b0 : nval - n0 >= what;
    endfunction
    task automatic wait_for(input int what, input int lim);
        int k;
        k = 0;
        while (!met(what) && k < lim) begin
            cyc(1);
            k++;
        end
        chk(met(what), "wait ran out");
    endtask
    task automatic wrap_up;
        $display("checks %0d mismatches %0d", tests_run, error_cnt);
        if (error_cnt == 0 && tests_run > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    task automatic t_single(input logic [3:0] l, input logic [2:0] s, input logic m,
                            input logic e);
        {len, sch, r10, ien} = {l, s, m, e};
        n0 = nval;
        chq.delete();
        rq.delete();
        pulse(sw_go);
        wait_for(-1, 3);
        wait_for(0, 400);
        cyc(1);
        chk(nval - n0 == int'(l), "conversion count");
        for (int i = 0; i < chq.size(); i++) begin
            chk(chq[i] === 3'(s + i), "channel order");
            chk(m ? rq[i] === {3'(s + i), 7'h15} : rq[i][9:8] === 2'b00, "result");
        end
        chk(cfl === 1'b1 && irq === e, "completion flag");
        pulse(cclr);
        cyc(1);
        chk(cfl === 1'b0 && irq === 1'b0, "completion clear");
    endtask
    task automatic t_scan;
        {scan, len} = {1'b1, 4'h1};
        n0 = nval;
        pulse(sw_go);
        wait_for(3, 200);
        chk(busy === 1'b1, "scan stopped");
        scan = 1'b0;
        wait_for(0, 100);
    endtask
    task automatic t_edge(input logic p);
        // Polarity and idle pin settle before the trigger is armed
        {tlev, tpol, pads[7]} = {1'b0, p, ~p};
        cyc(4);
        ten = 1'b1;
        cyc(5);
        pulse(sw_go);
        cyc(10);
        chk(busy === 1'b0, "software start taken");
        n0 = nval;
        pads[7] = p;
        wait_for(-1, 6);
        cyc(3);
        pads[7] = ~p;
        cyc(3);
        pads[7] = p;
        cyc(5);
        chk(ovf === 1'b1, "no overrun");
        wait_for(0, 100);
        cyc(10);
        chk(nval - n0 == 1 && busy === 1'b0, "edge sequence count");
        pulse(oclr);
        cyc(1);
        chk(ovf === 1'b0, "overrun kept");
        {ten, pads[7]} = 2'b01;
    endtask
    task automatic t_level(input logic p);
        // Polarity and idle pin settle before the trigger is armed
        {tlev, tpol, pads[7]} = {1'b1, p, ~p};
        cyc(4);
        ten = 1'b1;
        cyc(5);
        n0 = nval;
        pads[7] = p;
        wait_for(-1, 6);
        wait_for(2, 100);
        cyc(5);
        pads[7] = ~p;
        cyc(2);
        pads[7] = p;
        cyc(4);
        chk(ovf === 1'b0, "level overrun");
        pads[7] = ~p;
        wait_for(0, 100);
        cyc(20);
        chk(busy === 1'b0 && ovf === 1'b0, "level run went on");
        {ten, tlev, pads[7]} = 3'b001;
    endtask
    task automatic t_halt(input int md);
        len = 4'h1;
        pulse(sw_go);
        cyc(4);
        n0 = nval;
        {stp, wt, hiw} = md == 0 ? 3'b100 : md == 1 ? 3'b011 : 3'b010;
        cyc(40);
        chk(md < 2 ? nval == n0 && busy === 1'b1 : nval == n0 + 1, "halt");
        {stp, wt, hiw} = 3'b000;
        wait_for(0, 100);
        chk(nval == n0 + 1, "resume");
    endtask
    task automatic t_power;
        pulse(sw_go);
        cyc(5);
        pwr = 1'b0;
        cyc(3);
        chk(busy === 1'b0 && apw === 1'b0, "abort");
        n0 = nval;
        pulse(sw_go);
        cyc(30);
        chk(nval == n0 && busy === 1'b0, "start while off");
        pwr = 1'b1;
        cyc(2);
    endtask
    task automatic t_port;
        {pads, dien} = {8'ha5, 8'h0f};
        cyc(5);
        chk(pin === 8'hf5 && bufen === 8'h0f, "port gating");
        dien = 8'hff;
        cyc(5);
        chk(pin === 8'ha5, "port levels");
        {pads, dien} = {8'hff, 8'h00};
        cyc(5);
    endtask

    // Main sequence
    initial begin
        {rst_n, pwr, sw_go, scan, r10, ten, tlev, tpol} = '0;
        {oclr, ien, cclr, stp, wt, hiw} = '0;
        {len, sch, dien, pads} = {4'h1, 3'h0, 8'h00, 8'hff};
        {error_cnt, tests_run, nval, n0} = '0;
        cyc(2);
        rst_n = 1'b1;
        cyc(1);
        chk(pin === 8'hff && busy === 1'b0 && apw === 1'b0, "reset state");
        pulse(sw_go);
        cyc(5);
        chk(busy === 1'b0, "start while reset off");
        pwr = 1'b1;
        cyc(2);
        t_port;
        t_single(4'h3, 3'h6, 1'b1, 1'b1);
        t_single(4'h8, 3'h2, 1'b0, 1'b0);
        t_scan;
        t_edge(1'b0);
        t_edge(1'b1);
        t_level(1'b0);
        t_level(1'b1);
        for (int md = 0; md < 3; md++) t_halt(md);
        t_power;
        wrap_up;
    end
    // Watchdog
    initial begin
        repeat (20000) @(posedge clk);
        error_cnt++;
        wrap_up;
    end
endmodule
